// [verilog/frx_restart.sv]
// captures faulting channel accesses and reissues them on trap return
`include "frx_defs.svh"
module frx_restart (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst,
	// accesses issued by the core
	input  wire logic                acc_start,
	input  wire frx_pkg::frx_acc_s   acc_in,
	input  wire logic                acc_done,
	input  wire logic                acc_fault,
	input  wire logic                dest_overwrite,
	// trap entry and freeze control
	input  wire logic                trap_take,
	input  wire logic                freeze_clr,
	// handler writes to channel control
	input  wire logic                ctrl_wr,
	input  wire frx_pkg::frx_ctrl_s  ctrl_wdata,
	// return instructions and fetch progress
	input  wire logic                trap_return_op,
	input  wire logic                trap_return_flush_op,
	input  wire logic                fetch_done,
	// channel register contents
	output logic                     channel_freeze_bit,
	output frx_pkg::frx_acc_s        chan_out,
	// reissue toward the channel
	output logic                     reissue_go,
	output frx_pkg::frx_acc_s        reissue_acc,
	// branch target cache invalidate
	output logic                     btc_flush
);

	////////////////////////////////////////////////////////////////
	// freeze bit

	logic frz_reg;
	logic frz_next;
	logic ret_any;

	assign ret_any = trap_return_op | trap_return_flush_op;

	// trap entry wins over clear and return
	always_comb begin
		frz_next = frz_reg;
		if (freeze_clr || ret_any) begin
			frz_next = 1'b0;
		end
		if (trap_take) begin
			frz_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			frz_reg <= 1'b0;
		end else begin
			frz_reg <= frz_next;
		end
	end

	assign channel_freeze_bit = frz_reg;

	////////////////////////////////////////////////////////////////
	// channel address, data and control

	frx_pkg::frx_acc_s chan_reg;
	frx_pkg::frx_acc_s chan_next;
	logic              track;

	// no instruction address is kept, only the access itself
	assign track = !frz_reg;

	always_comb begin
		chan_next = chan_reg;
		// handler may rewrite control, e.g. drop incomplete
		if (ctrl_wr) begin
			chan_next.ctrl = ctrl_wdata;
		end
		if (track) begin
			if (acc_start) begin
				chan_next = acc_in;
				chan_next.ctrl.incomplete = 1'b1;
				chan_next.ctrl.unneeded = 1'b0;
			end else if (acc_done && chan_reg.ctrl.incomplete) begin
				if (chan_reg.ctrl.mult && chan_reg.ctrl.cnt != `FRX_CNT_ZERO) begin
					// step to the next word, still incomplete
					chan_next.addr = chan_reg.addr + `FRX_WORD_STEP;
					chan_next.ctrl.cnt = chan_reg.ctrl.cnt - `FRX_CNT_ONE;
					chan_next.ctrl.dest = chan_reg.ctrl.dest + `FRX_DEST_W'(1);
				end else begin
					// a fault in the same cycle keeps the access pending
					chan_next.ctrl.incomplete = acc_fault;
				end
			end else if (acc_fault) begin
				chan_next.ctrl.incomplete = 1'b1;
			end
			// destination overwritten: result must not be written back
			if (dest_overwrite && !acc_start && chan_reg.ctrl.incomplete
					&& !chan_reg.ctrl.wr) begin
				chan_next.ctrl.unneeded = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			chan_reg.addr <= `FRX_ADDR_RST;
			chan_reg.data <= `FRX_DATA_RST;
			chan_reg.ctrl <= '0;
		end else begin
			chan_reg <= chan_next;
		end
	end

	assign chan_out = chan_reg;

	////////////////////////////////////////////////////////////////
	// reissue sequencer

	frx_pkg::frx_state_e st_reg;
	frx_pkg::frx_state_e st_next;
	logic [1:0]          fcnt_reg;
	logic [1:0]          fcnt_next;
	logic                go_reg;
	logic                go_next;
	frx_pkg::frx_acc_s   racc_reg;
	frx_pkg::frx_acc_s   racc_next;
	logic                flush_reg;
	logic                flush_next;
	logic                restart_ok;

	// pending and still wanted
	assign restart_ok = chan_reg.ctrl.incomplete && !chan_reg.ctrl.unneeded;

	always_comb begin
		st_next    = st_reg;
		fcnt_next  = fcnt_reg;
		go_next    = 1'b0;
		racc_next  = racc_reg;
		flush_next = 1'b0;
		// invalidate only once the return executes
		if (trap_return_flush_op) begin
			flush_next = 1'b1;
		end
		unique case (st_reg)
			frx_pkg::FRX_IDLE: begin
				if (ret_any && restart_ok) begin
					fcnt_next = `FRX_FETCH_ZERO;
					// reissue from saved registers
					if (chan_reg.ctrl.mult) begin
						st_next = frx_pkg::FRX_WAIT_FETCH;
					end else begin
						st_next = frx_pkg::FRX_ISSUE;
					end
				end
			end
			frx_pkg::FRX_WAIT_FETCH: begin
				if (fetch_done) begin
					fcnt_next = fcnt_reg + `FRX_FETCH_ONE;
					if (fcnt_reg + `FRX_FETCH_ONE == `FRX_FETCH_NEED) begin
						st_next = frx_pkg::FRX_ISSUE;
					end
				end
			end
			frx_pkg::FRX_ISSUE: begin
				// same access again, so the result is unchanged
				go_next   = 1'b1;
				racc_next = chan_reg;
				st_next   = frx_pkg::FRX_IDLE;
			end
			// the fourth code is unused; fall back to idle
			default: begin
				st_next = frx_pkg::FRX_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_reg    <= frx_pkg::FRX_IDLE;
			fcnt_reg  <= `FRX_FETCH_ZERO;
			go_reg    <= 1'b0;
			racc_reg  <= '0;
			flush_reg <= 1'b0;
		end else begin
			st_reg    <= st_next;
			fcnt_reg  <= fcnt_next;
			go_reg    <= go_next;
			racc_reg  <= racc_next;
			flush_reg <= flush_next;
		end
	end

	assign reissue_go  = go_reg;
	assign reissue_acc = racc_reg;
	assign btc_flush   = flush_reg;

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// fetches seen since the last accepted return, kept apart from the sequencer
	logic [1:0] fchk_reg;
	logic [1:0] fchk_next;

	// counts up to two and sticks there; an accepted return restarts it
	always_comb begin
		fchk_next = fchk_reg;
		if (ret_any && st_reg == frx_pkg::FRX_IDLE && restart_ok) begin
			fchk_next = `FRX_FETCH_ZERO;
		end else if (fetch_done && fchk_reg != `FRX_FETCH_NEED) begin
			fchk_next = fchk_reg + `FRX_FETCH_ONE;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fchk_reg <= `FRX_FETCH_ZERO;
		end else begin
			fchk_reg <= fchk_next;
		end
	end

	sequence s_ret_ok_single;
		ret_any && st_reg == frx_pkg::FRX_IDLE && restart_ok && !chan_reg.ctrl.mult;
	endsequence

	sequence s_ret_ok_mult;
		ret_any && st_reg == frx_pkg::FRX_IDLE && restart_ok && chan_reg.ctrl.mult;
	endsequence

	sequence s_mult_resumed;
		reissue_go && reissue_acc.ctrl.mult;
	endsequence

	a_capture_access: assert property (
		acc_start && !frz_reg && !trap_take
		|=> chan_reg.addr == $past(acc_in.addr) && chan_reg.data == $past(acc_in.data)
			&& chan_reg.ctrl.incomplete)
		else $error("access not captured");

	a_freeze_holds: assert property (
		frz_reg && !ctrl_wr |=> $stable(chan_reg.addr) && $stable(chan_reg.data))
		else $error("frozen channel registers changed");

	a_trap_freezes: assert property (
		trap_take |=> frz_reg [*1] ##0 channel_freeze_bit)
		else $error("trap did not freeze");

	a_unneeded_mark: assert property (
		!frz_reg && dest_overwrite && !acc_start && !ctrl_wr
			&& chan_reg.ctrl.incomplete && !chan_reg.ctrl.wr
		|=> chan_reg.ctrl.unneeded)
		else $error("overwrite not marked unneeded");

	a_no_reissue: assert property (
		ret_any && st_reg == frx_pkg::FRX_IDLE && !restart_ok |=> !reissue_go [*3])
		else $error("reissue without valid pending access");

	a_single_reissue: assert property (
		s_ret_ok_single |=> ##1 reissue_go && reissue_acc.addr == $past(chan_reg.addr, 2))
		else $error("single access not reissued");

	a_mult_wait: assert property (
		s_mult_resumed |-> fchk_reg == `FRX_FETCH_NEED)
		else $error("multiple transfer resumed before two fetches");

	a_mult_enter: assert property (
		s_ret_ok_mult |=> st_reg == frx_pkg::FRX_WAIT_FETCH && !reissue_go)
		else $error("multiple transfer did not wait for fetches");

	a_mult_resume: assert property (
		st_reg == frx_pkg::FRX_WAIT_FETCH && fcnt_reg == `FRX_FETCH_ONE && fetch_done
		|=> ##1 reissue_go && reissue_acc.ctrl.mult)
		else $error("multiple transfer not resumed");

	a_mult_step: assert property (
		!frz_reg && !acc_start && !ctrl_wr && acc_done && chan_reg.ctrl.incomplete
			&& chan_reg.ctrl.mult && chan_reg.ctrl.cnt != `FRX_CNT_ZERO
		|=> chan_reg.addr == $past(chan_reg.addr) + `FRX_WORD_STEP
			&& chan_reg.ctrl.incomplete)
		else $error("multiple transfer did not advance");

	a_flush_on_ret: assert property (
		trap_return_flush_op |=> btc_flush ##1 !btc_flush || $past(trap_return_flush_op))
		else $error("flush not on return");

	a_flush_only_ret: assert property (
		btc_flush |-> $past(trap_return_flush_op))
		else $error("flush without flushing return");

	a_reissue_pulse: assert property (
		reissue_go |=> !reissue_go)
		else $error("reissue held longer than one cycle");

	a_fault_pending: assert property (
		!frz_reg && acc_fault |=> chan_reg.ctrl.incomplete)
		else $error("faulted access not marked incomplete");

endmodule

// [verilog/frx_defs.svh]
// constants for the faulting access restart unit
`ifndef FRX_DEFS_SVH
`define FRX_DEFS_SVH
`define FRX_ADDR_W     32
`define FRX_DATA_W     32
`define FRX_CNT_W      8
`define FRX_DEST_W     8
`define FRX_WORD_STEP  32'h0000_0004
`define FRX_FETCH_NEED 2'h2
`define FRX_FETCH_ZERO 2'h0
`define FRX_FETCH_ONE  2'h1
`define FRX_CNT_ZERO   8'h00
`define FRX_CNT_ONE    8'h01
`define FRX_ADDR_RST   32'h0000_0000
`define FRX_DATA_RST   32'h0000_0000
`endif

// [verilog/frx_pkg.sv]
// types for the faulting access restart unit
`include "frx_defs.svh"
package frx_pkg;
	// channel control word
	typedef struct packed {
		logic                    incomplete; // access_incomplete_flag
		logic                    unneeded;   // data_unneeded_flag
		logic                    wr;         // store when set
		logic                    mult;       // multiple-word transfer
		logic [`FRX_CNT_W-1:0]   cnt;        // words left after current one
		logic [`FRX_DEST_W-1:0]  dest;       // destination or source register
	} frx_ctrl_s;
	// one external access
	typedef struct packed {
		logic [`FRX_ADDR_W-1:0]  addr;
		logic [`FRX_DATA_W-1:0]  data;
		frx_ctrl_s               ctrl;
	} frx_acc_s;
	typedef enum logic [1:0] {
		FRX_IDLE,
		FRX_WAIT_FETCH,
		FRX_ISSUE
	} frx_state_e;
endpackage

// [testbench/frx_chan_mem.sv]
// channel-side model completing reissued accesses word by word
module frx_chan_mem #(
	parameter int LAT = 2
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// reissue from the unit
	input  wire logic              reissue_go,
	input  wire frx_pkg::frx_acc_s reissue_acc,
	// word completion back to the unit
	output logic                   mem_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] left_reg;
	int         wait_reg;
	////////////////////////////////////////////////////////////////////////////////
	// one done pulse per word, LAT idle cycles between words
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_done <= 1'b0;
			left_reg <= 9'h000;
			wait_reg <= 0;
		end else begin
			mem_done <= 1'b0;
			if (reissue_go) begin
				left_reg <= {1'b0, reissue_acc.ctrl.cnt} + 9'h001;
				wait_reg <= LAT;
			end else if (left_reg != 9'h000) begin
				if (wait_reg == 0) begin
					mem_done <= 1'b1;
					left_reg <= left_reg - 9'h001;
					wait_reg <= LAT;
				end else begin
					wait_reg <= wait_reg - 1;
				end
			end
		end
	end
endmodule

// [testbench/faulting_access_restart_tb.sv]
// self-checking bench for the faulting access restart unit
module faulting_access_restart_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {frx_pkg::frx_acc_s a; frx_pkg::frx_acc_s e;} frx_row_s;
	logic               core_clk, rst, acc_start, tb_done, mem_done, acc_fault, dest_overwrite;
	logic               trap_take, freeze_clr, ctrl_wr, trap_return_op, trap_return_flush_op;
	logic               fetch_done, channel_freeze_bit, reissue_go, btc_flush, seen;
	frx_pkg::frx_acc_s  acc_in, chan_out, reissue_acc, exp_acc, got;
	frx_pkg::frx_ctrl_s ctrl_wdata;
	frx_row_s           rows [3];
	int                 error_cnt, check_count, cyc;
	////////////////////////////////////////////////////////////////////////////////
	frx_restart frx_restart_inst (.core_clk(core_clk), .rst(rst), .acc_start(acc_start),
		.acc_in(acc_in), .acc_done(tb_done | mem_done), .acc_fault(acc_fault),
		.dest_overwrite(dest_overwrite), .trap_take(trap_take), .freeze_clr(freeze_clr),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .trap_return_op(trap_return_op),
		.trap_return_flush_op(trap_return_flush_op), .fetch_done(fetch_done),
		.channel_freeze_bit(channel_freeze_bit), .chan_out(chan_out),
		.reissue_go(reissue_go), .reissue_acc(reissue_acc), .btc_flush(btc_flush));
	frx_chan_mem frx_chan_mem_inst (.core_clk(core_clk), .rst(rst), .reissue_go(reissue_go),
		.reissue_acc(reissue_acc), .mem_done(mem_done));
	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// shared helpers
	function automatic frx_pkg::frx_acc_s mk(input logic [31:0] a, d, input logic [3:0] f,
		input logic [7:0] c, t);
		return {a, d, f, c, t}; // f = incomplete, unneeded, wr, mult
	endfunction
	task automatic check(input string n, input logic [83:0] s, input logic [83:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic go(input logic [9:0] p);
		@(posedge core_clk);
		#1;
		{acc_start, tb_done, acc_fault, dest_overwrite, trap_take, freeze_clr, ctrl_wr,
			trap_return_op, trap_return_flush_op, fetch_done} = p;
		@(posedge core_clk);
		#1;
		{acc_start, tb_done, acc_fault, dest_overwrite, trap_take, freeze_clr, ctrl_wr,
			trap_return_op, trap_return_flush_op, fetch_done} = 10'h000;
	endtask
	task automatic wait_go(input int n);
		seen = 1'b0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (reissue_go === 1'b1 && seen === 1'b0) begin
				seen = 1'b1;
				got = reissue_acc;
			end
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{acc_start, tb_done, acc_fault, dest_overwrite, trap_take, freeze_clr, ctrl_wr,
			trap_return_op, trap_return_flush_op, fetch_done} = 10'h000;
		acc_in = '0;
		ctrl_wdata = '0;
		got = '0;
		rst = 1'b1;
		rows[0] = {mk(32'h0000_1000, 32'h1111_0000, 4'h0, 8'h00, 8'h03),
			mk(32'h0000_1000, 32'h1111_0000, 4'h8, 8'h00, 8'h03)};
		rows[1] = {mk(32'h0000_1004, 32'h2222_0000, 4'h2, 8'h00, 8'h04),
			mk(32'h0000_1004, 32'h2222_0000, 4'ha, 8'h00, 8'h04)};
		rows[2] = {mk(32'hffff_fffc, 32'hffff_ffff, 4'h2, 8'h00, 8'hff),
			mk(32'hffff_fffc, 32'hffff_ffff, 4'ha, 8'h00, 8'hff)};
		repeat (8) @(posedge core_clk);
		#1;
		rst = 1'b0;
		check("rst_chan", chan_out, 84'h0);
		check("rst_freeze", 84'(channel_freeze_bit), 84'h0);
		foreach (rows[i]) begin
			acc_in = rows[i].a;
			go(10'h200);
			check("chan_start", chan_out, rows[i].e);
			go(10'h100);
			exp_acc = rows[i].e;
			exp_acc.ctrl.incomplete = 1'b0;
			check("chan_done", chan_out, exp_acc);
		end
		// overwritten load destination, frozen tracking, return refused
		acc_in = mk(32'h0000_2000, 32'h0, 4'h0, 8'h00, 8'h05);
		go(10'h200);
		go(10'h040);
		exp_acc = mk(32'h0000_2000, 32'h0, 4'hc, 8'h00, 8'h05);
		check("unneeded", chan_out, exp_acc);
		go(10'h020);
		check("freeze_set", 84'(channel_freeze_bit), 84'h1);
		acc_in = mk(32'h0000_3000, 32'h5, 4'h0, 8'h00, 8'h01);
		go(10'h200);
		check("frozen", chan_out, exp_acc);
		go(10'h004);
		wait_go(6);
		check("no_reissue_nn", 84'(seen), 84'h0);
		go(10'h020);
		go(10'h010);
		check("freeze_clr", 84'(channel_freeze_bit), 84'h0);
		// faulted store reissued by the flushing return
		acc_in = mk(32'h0000_4000, 32'hdead_0001, 4'h2, 8'h00, 8'h07);
		go(10'h200);
		go(10'h080);
		go(10'h020);
		go(10'h002);
		check("flush", 84'(btc_flush), 84'h1);
		exp_acc = mk(32'h0000_4000, 32'hdead_0001, 4'ha, 8'h00, 8'h07);
		wait_go(4);
		check("reissue", got, exp_acc);
		wait_go(6);
		exp_acc.ctrl.incomplete = 1'b0;
		check("reissue_done", chan_out, exp_acc);
		// handler emulated the store and cleared incomplete
		go(10'h200);
		go(10'h080);
		go(10'h020);
		ctrl_wdata = exp_acc.ctrl;
		go(10'h008);
		go(10'h004);
		wait_go(6);
		check("no_reissue_cv", 84'(seen), 84'h0);
		// interrupted multiple load resumes mid-sequence after two fetches
		acc_in = mk(32'h0000_8000, 32'h0, 4'h1, 8'h03, 8'h10);
		go(10'h200);
		go(10'h100);
		go(10'h100);
		exp_acc = mk(32'h0000_8008, 32'h0, 4'h9, 8'h01, 8'h12);
		check("mult_step", chan_out, exp_acc);
		go(10'h020);
		go(10'h004);
		go(10'h001);
		wait_go(3);
		check("early_resume", 84'(seen), 84'h0);
		go(10'h001);
		wait_go(4);
		check("mult_reissue", got, exp_acc);
		wait_go(8);
		check("mult_end", chan_out, mk(32'h0000_800c, 32'h0, 4'h1, 8'h00, 8'h13));
		// reset in mid-run while frozen with an access pending
		acc_in = mk(32'h0000_9000, 32'h0, 4'h0, 8'h00, 8'h01);
		go(10'h200);
		go(10'h020);
		rst = 1'b1;
		@(posedge core_clk);
		#1;
		rst = 1'b0;
		check("rst_again_chan", chan_out, 84'h0);
		check("rst_again_freeze", 84'(channel_freeze_bit), 84'h0);
		go(10'h004);
		wait_go(4);
		check("rst_no_reissue", 84'(seen), 84'h0);
		test_done();
	end
endmodule
